/* design/scr_factor_decode.sv */
/*
  Registered ratio decoder: turns a W-bit register field into the ratio
  it stands for, where an all-zero field means two to the power W.
  Assumes the field comes from a register in the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module scr_factor_decode
  import scr_pkg::*;
#(
  parameter int         W         = 8,
  parameter logic [W:0] RESET_VAL = (W+1)'(1)
) (
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] field_i,
  output logic      [W:0]   factor_o
);

  logic [W:0] next_factor;

  // A zero field selects the largest ratio, one past the field range.
  always_comb begin
    next_factor = factor_o;
    if (ce_i) begin
      if (field_i == '0) begin
        next_factor = {1'b1, {W{1'b0}}};
      end else begin
        next_factor = {1'b0, field_i};
      end
    end
  end

  // The analog side sees a steady ratio, never a decode glitch.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      factor_o <= RESET_VAL;
    end else begin
      factor_o <= next_factor;
    end
  end

endmodule

`default_nettype wire

/* design/scr_lock_track.sv */
/*
  Lock qualifier: shows the loop's lock report only while the loop is
  powered and running, and only after it has held for FILTER cycles.
  Assumes loop_locked_i is synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module scr_lock_track
  import scr_pkg::*;
#(
  parameter int FILTER = SCR_LOCK_FILTER
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  input  wire logic run_ok_i,
  input  wire logic restart_i,
  input  wire logic loop_locked_i,
  output logic      locked_o
);

  localparam int CW = $clog2(FILTER + 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_locked;

  // Any drop of power, run or lock starts qualification again.
  always_comb begin
    next_count  = count;
    next_locked = locked_o;
    if (ce_i) begin
      if (!run_ok_i || restart_i || !loop_locked_i) begin
        next_count  = '0;
        next_locked = 1'b0;
      end else if (count < CW'(FILTER)) begin
        next_count  = count + CW'(1);
        next_locked = (count + CW'(1)) == CW'(FILTER);
      end else begin
        next_locked = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count    <= '0;
      locked_o <= 1'b0;
    end else begin
      count    <= next_count;
      locked_o <= next_locked;
    end
  end

endmodule

`default_nettype wire

/* design/scr_pkg.sv */
/*
  Constants for the clock synthesizer control registers: register
  addresses, bit positions, write masks, reset values and timing counts.
  Assumes an 8-bit special-function register port on a paged map.
*/
`default_nettype none

package scr_pkg;

  // Register page on which the four registers live.
  localparam logic [7:0] SCR_PAGE          = 8'h0F;

  // Register addresses as printed.
  localparam logic [7:0] SCR_ADDR_CONTROL  = 8'h89;
  localparam logic [7:0] SCR_ADDR_PREDIV   = 8'h8D;
  localparam logic [7:0] SCR_ADDR_MULT     = 8'h8F;
  localparam logic [7:0] SCR_ADDR_FILTER   = 8'h8F;

  // Control register bit positions.
  localparam int         SCR_CTL_PWR_BIT   = 0;
  localparam int         SCR_CTL_RUN_BIT   = 1;
  localparam int         SCR_CTL_SRC_BIT   = 2;
  localparam int         SCR_CTL_RSVD_BIT  = 3;
  localparam int         SCR_CTL_LOCK_BIT  = 4;

  // Filter register field positions.
  localparam int         SCR_FLT_LP_LSB    = 0;
  localparam int         SCR_FLT_LP_W      = 4;
  localparam int         SCR_FLT_OSC_LSB   = 4;
  localparam int         SCR_FLT_OSC_W     = 2;

  // Field widths of the ratio registers.
  localparam int         SCR_PREDIV_W      = 5;
  localparam int         SCR_MULT_W        = 8;

  // Writable bits of each register; all others read as zero, except the lock flag in control bit 4.
  localparam logic [7:0] SCR_CTL_WR_MASK   = 8'h0F;
  localparam logic [7:0] SCR_DIV_WR_MASK   = 8'h1F;
  localparam logic [7:0] SCR_MUL_WR_MASK   = 8'hFF;
  localparam logic [7:0] SCR_FLT_WR_MASK   = 8'h3F;

  // Reset values.
  localparam logic [7:0] SCR_CTL_RESET     = 8'h00;
  localparam logic [7:0] SCR_DIV_RESET     = 8'h01;
  localparam logic [7:0] SCR_MUL_RESET     = 8'h01;
  localparam logic [7:0] SCR_FLT_RESET     = 8'h31;

  // Cycles the loop must report lock in a row before the flag is shown.
  localparam int         SCR_LOCK_FILTER   = 2;

endpackage

`default_nettype wire

/* design/scr_synth_ctrl.sv */
/*
  Control and status registers of the on-chip clock synthesizer, reached
  through the 8-bit special-function register port of the processor core.
  Assumes a single system clock, an analog loop that reports lock
  synchronously, and a core that drives one access strobe per cycle.
  Writes land at the edge that takes them; read data stands on the
  output from the following cycle until the next taken read. The ratio
  outputs follow their registers one edge later. While the clock enable
  is low every register, the read data and the lock qualification hold.
  The analog side is expected to treat every control output as a level
  that may change at any clock edge, never as a pulse.
*/
`timescale 1ns/1ps
`default_nettype none

module scr_synth_ctrl
  import scr_pkg::*;
#(
  parameter logic [7:0] CTL_ADDR    = SCR_ADDR_CONTROL,
  parameter logic [7:0] DIV_ADDR    = SCR_ADDR_PREDIV,
  parameter logic [7:0] MUL_ADDR    = SCR_ADDR_MULT,
  parameter logic [7:0] FLT_ADDR    = SCR_ADDR_FILTER,
  parameter int         LOCK_FILTER = SCR_LOCK_FILTER
) (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       ce_i,
  // Register port of the core.
  input  wire logic [7:0] sfr_page_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  output logic            sfr_hit_o,
  output logic      [7:0] sfr_rdata_o,
  // Analog loop side.
  input  wire logic       loop_locked_i,
  output logic            reference_source_select_o,
  output logic            synth_run_enable_o,
  output logic            bias_power_enable_o,
  output logic      [5:0] predivide_factor_o,
  output logic      [8:0] multiply_factor_o,
  output logic      [1:0] osc_range_select_o,
  output logic      [3:0] loop_filter_range_o,
  output logic            lock_indicator_o
);

  // True when the access targets the given register on our page.
  function automatic logic addr_hit(
    input logic [7:0] page,
    input logic [7:0] addr,
    input logic [7:0] target
  );
    addr_hit = (page == SCR_PAGE) && (addr == target);
  endfunction

  // Keeps only the writable positions of a register image. The same mask
  // serves the write and the read path, so a position outside the mask can never
  // hold a one and reads back as zero, except control bit 4, which shows the lock flag.
  function automatic logic [7:0] keep_writable(
    input logic [7:0] value,
    input logic [7:0] mask
  );
    keep_writable = value & mask;
  endfunction

  // Register map, all on one register page:
  //   control     bit 0 bias power, bit 1 run, bit 2 reference source,
  //               bit 3 reserved, bit 4 qualified lock (read only),
  //               bits 7..5 read zero.
  //   predivider  bits 4..0 ratio, zero meaning 32; bits 7..5 read zero.
  //   multiplier  bits 7..0 ratio, zero meaning 256.
  //   filter      bits 3..0 loop filter code, bits 5..4 oscillator
  //               range, bits 7..6 read zero.
  // Multiplier and filter share one address by default; a write there
  // lands in both and a read returns the multiplier, so a system that
  // needs the filter readable moves it with FLT_ADDR.
  // Bias power must come up before run; the block does not enforce the
  // order, it only keeps the lock flag clear until both are on.

  // Stored register images, positions outside the write masks kept at zero.
  logic [7:0] synth_control;
  logic [7:0] synth_predivider;
  logic [7:0] synth_multiplier;
  logic [7:0] synth_filter_config;
  logic [7:0] next_control;
  logic [7:0] next_predivider;
  logic [7:0] next_multiplier;
  logic [7:0] next_filter_config;
  logic [7:0] next_rdata;

  logic       hit_ctl;
  logic       hit_div;
  logic       hit_mul;
  logic       hit_flt;
  logic       wr_ok;
  logic       rd_ok;
  logic       run_ok;
  logic       cfg_restart;
  logic       locked_flag;
  // Per-register change flags feeding the lock restart.
  logic       div_changed;
  logic       mul_changed;
  logic       flt_changed;
  logic       src_changed;

  // Address decode for the four registers. The page must match as well,
  // since the same addresses carry other registers on other pages.
  always_comb begin
    hit_ctl = addr_hit(sfr_page_i, sfr_addr_i, CTL_ADDR);
    hit_div = addr_hit(sfr_page_i, sfr_addr_i, DIV_ADDR);
    hit_mul = addr_hit(sfr_page_i, sfr_addr_i, MUL_ADDR);
    hit_flt = addr_hit(sfr_page_i, sfr_addr_i, FLT_ADDR);
  end

  // The hit flag lets the core's read mux pick our data; it is combinational
  // on purpose so the core can steer it in the access cycle. Strobes are
  // only taken while the clock enable is high; a strobe in a frozen cycle
  // is lost, so the core must hold its access off then.
  assign sfr_hit_o = hit_ctl | hit_div | hit_mul | hit_flt;
  assign wr_ok     = ce_i & sfr_wr_i;
  assign rd_ok     = ce_i & sfr_rd_i;

  // The loop may only be reported running when bias and run are both on.
  // Run without bias is a software fault; the loop then cannot lock, and
  // the flag must not claim otherwise.
  assign run_ok = synth_control[SCR_CTL_RUN_BIT]
                & synth_control[SCR_CTL_PWR_BIT];

  // Write path: each register keeps only its writable positions. A write
  // to the shared multiplier and filter address lands in both registers,
  // which is the only sensible reading of one address for two images.
  // The lock position of the control image is never stored; it is
  // inserted live on the read side.
  always_comb begin
    next_control       = synth_control;
    next_predivider    = synth_predivider;
    next_multiplier    = synth_multiplier;
    next_filter_config = synth_filter_config;
    if (wr_ok) begin
      if (hit_ctl) begin
        // Bits 7..5 are dropped and bit 4 is never stored here.
        next_control = keep_writable(sfr_wdata_i, SCR_CTL_WR_MASK);
      end
      if (hit_div) begin
        next_predivider = keep_writable(sfr_wdata_i, SCR_DIV_WR_MASK);
      end
      if (hit_mul) begin
        next_multiplier = keep_writable(sfr_wdata_i, SCR_MUL_WR_MASK);
      end
      if (hit_flt) begin
        next_filter_config = keep_writable(sfr_wdata_i, SCR_FLT_WR_MASK);
      end
    end
  end

  // Which stored settings the write taken in this cycle really changes;
  // rewriting a register with its own value must not disturb the loop.
  always_comb begin
    div_changed = hit_div && (next_predivider != synth_predivider);
    mul_changed = hit_mul && (next_multiplier != synth_multiplier);
    flt_changed = hit_flt && (next_filter_config != synth_filter_config);
    src_changed = hit_ctl
                && (next_control[SCR_CTL_SRC_BIT] != synth_control[SCR_CTL_SRC_BIT]);
  end

  // A ratio, filter or source change under a running loop invalidates the
  // old lock; the analog loop needs time to settle on the new target.
  // Changes made while the loop is stopped need no restart, because the
  // lock qualification is already held clear then.
  always_comb begin
    cfg_restart = 1'b0;
    if (wr_ok && run_ok) begin
      cfg_restart = div_changed | mul_changed | flt_changed | src_changed;
    end
  end

  // Read path: the control image gains the live lock flag in bit 4.
  // A read that hits nothing returns zero, so the core's read mux may
  // OR several peripherals together without a separate select. The
  // reserved control bit 3 reads back as stored.
  always_comb begin
    next_rdata = sfr_rdata_o;
    if (rd_ok) begin
      next_rdata = 8'h00;
      if (hit_ctl) begin
        next_rdata = keep_writable(synth_control, SCR_CTL_WR_MASK);
        next_rdata[SCR_CTL_LOCK_BIT] = locked_flag;
      end else if (hit_div) begin
        next_rdata = keep_writable(synth_predivider, SCR_DIV_WR_MASK);
      end else if (hit_mul) begin
        // At the shared address the multiplier wins the read, and the
        // filter is then write-only until FLT_ADDR moves it.
        next_rdata = synth_multiplier;
      end else if (hit_flt) begin
        next_rdata = keep_writable(synth_filter_config, SCR_FLT_WR_MASK);
      end
    end
  end

  // Register state; the clock enable freezes it all. Only constants are
  // loaded in the reset branch so the reset path stays free of logic.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      synth_control       <= SCR_CTL_RESET;
      synth_predivider    <= SCR_DIV_RESET;
      synth_multiplier    <= SCR_MUL_RESET;
      synth_filter_config <= SCR_FLT_RESET;
      sfr_rdata_o         <= 8'h00;
    end else begin
      synth_control       <= next_control;
      synth_predivider    <= next_predivider;
      synth_multiplier    <= next_multiplier;
      synth_filter_config <= next_filter_config;
      sfr_rdata_o         <= next_rdata;
    end
  end

  // Controls straight from register bits, so they are glitch free.
  // The reserved bit 3 is stored and read back but steers nothing;
  // software is expected to keep it at zero.
  // Dropping run while bias stays on holds the synthesizer in reset
  // without losing bias settling; clearing both at once is allowed.
  assign reference_source_select_o = synth_control[SCR_CTL_SRC_BIT];
  assign synth_run_enable_o        = synth_control[SCR_CTL_RUN_BIT];
  assign bias_power_enable_o       = synth_control[SCR_CTL_PWR_BIT];

  // Range codes pass as written; choosing the right code is software's job.
  // No check is made that a code suits the programmed ratio: a wrong code
  // shows up only as a loop that is slow to lock or never locks.
  assign osc_range_select_o  = synth_filter_config[SCR_FLT_OSC_LSB +: SCR_FLT_OSC_W];
  assign loop_filter_range_o = synth_filter_config[SCR_FLT_LP_LSB +: SCR_FLT_LP_W];

  // Pre-divider ratio, zero meaning the full 32; the loop output is
  // reference times multiply_factor_o over predivide_factor_o.
  // The ratio is registered once more so that a field of zero never
  // reaches the analog divider as a ratio of zero, even for one cycle.
  scr_factor_decode #(
    .W         (SCR_PREDIV_W),
    .RESET_VAL (6'(SCR_DIV_RESET))
  ) u_prediv (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .ce_i     (ce_i),
    .field_i  (synth_predivider[SCR_PREDIV_W-1:0]),
    .factor_o (predivide_factor_o)
  );

  // Multiplier ratio, zero meaning the full 256. Its nine-bit output
  // carries 256 without a wrap to zero.
  scr_factor_decode #(
    .W         (SCR_MULT_W),
    .RESET_VAL (9'(SCR_MUL_RESET))
  ) u_mult (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .ce_i     (ce_i),
    .field_i  (synth_multiplier),
    .factor_o (multiply_factor_o)
  );

  // Lock is qualified over a few cycles so a single report of lock from
  // a loop still pulling in does not let software switch clocks early.
  // The qualifier clears at once on loss of bias, run or lock and on a
  // restart; with the default filter the flag rises on the second edge of
  // steady lock. The trade is a short delay before software may switch
  // the system clock, against never seeing a lock that will not hold.
  scr_lock_track #(
    .FILTER (LOCK_FILTER)
  ) u_lock (
    .clk_i         (clk_i),
    .nrst_i        (nrst_i),
    .ce_i          (ce_i),
    .run_ok_i      (run_ok),
    .restart_i     (cfg_restart),
    .loop_locked_i (loop_locked_i),
    .locked_o      (locked_flag)
  );

  // The status output and control bit 4 show one and the same flag.
  assign lock_indicator_o = locked_flag;

endmodule

`default_nettype wire

/* test/scr_loop_model.sv */
/* Behavioural analog loop: reports lock a set number of cycles after it is
   biased and released from reset. Assumes it runs on the system clock. */
`timescale 1ns/1ps
`default_nettype none
module scr_loop_model (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       pwr_i,
  input  wire logic       run_i,
  input  wire logic       drop_i,
  input  wire logic [7:0] delay_i,
  output logic            locked_o
);
  logic [7:0] cnt;
  // Settling count, cleared while unbiased or held in reset.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) cnt <= 8'h00;
    else if (!(pwr_i && run_i)) cnt <= 8'h00;
    else if (cnt < delay_i) cnt <= cnt + 8'h01;
  end
  // A commanded drop stands for a loop that loses lock.
  assign locked_o = pwr_i && run_i && !drop_i && cnt >= delay_i;
endmodule
`default_nettype wire

/* test/scr_synth_ctrl_sva.sv */
/* Assertion checker for the synthesizer control block, bound to it below.
   Assumes one clock domain with an asynchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module scr_synth_ctrl_sva
  import scr_pkg::*;
#(
  parameter int LOCK_FILTER = SCR_LOCK_FILTER
) (
  input wire logic       clk_i,
  input wire logic       nrst_i,
  input wire logic       ce_i,
  input wire logic [7:0] sfr_page_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic       sfr_wr_i,
  input wire logic       sfr_rd_i,
  input wire logic       sfr_hit_o,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       loop_locked_i,
  input wire logic       reference_source_select_o,
  input wire logic       synth_run_enable_o,
  input wire logic       bias_power_enable_o,
  input wire logic [5:0] predivide_factor_o,
  input wire logic [8:0] multiply_factor_o,
  input wire logic       lock_indicator_o
);
  logic [2:0] ctl;
  logic       on_ctl, on_div, on_mul;
  int         run_n;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Which register a strobe taken on this edge lands in.
  assign ctl    = {reference_source_select_o, synth_run_enable_o, bias_power_enable_o};
  assign on_ctl = ce_i && sfr_page_i == SCR_PAGE && sfr_addr_i == SCR_ADDR_CONTROL;
  assign on_div = ce_i && sfr_page_i == SCR_PAGE && sfr_addr_i == SCR_ADDR_PREDIV;
  assign on_mul = ce_i && sfr_page_i == SCR_PAGE && sfr_addr_i == SCR_ADDR_MULT;
  // Edges in a row with the loop biased, running and locked; the flag may not rise sooner.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) run_n <= 0;
    else if (ce_i) run_n <= (loop_locked_i && ctl[1:0] == 2'b11) ? run_n + 1 : 0;
  end
  sequence s_wr_div; sfr_wr_i && on_div; endsequence
  sequence s_wr_mul; sfr_wr_i && on_mul; endsequence
  property p_ctl_wr; sfr_wr_i && on_ctl |=> ctl == $past(sfr_wdata_i[2:0]); endproperty
  a_ctl_wr: assert property (p_ctl_wr) else $error("control outputs wrong");
  property p_div;
    s_wr_div |-> ##2 predivide_factor_o ==
      (($past(sfr_wdata_i[4:0], 2) == 5'h00) ? 6'd32 : {1'b0, $past(sfr_wdata_i[4:0], 2)});
  endproperty
  a_div: assert property (p_div) else $error("predivide factor wrong");
  property p_mul;
    s_wr_mul |-> ##2 multiply_factor_o ==
      (($past(sfr_wdata_i, 2) == 8'h00) ? 9'd256 : {1'b0, $past(sfr_wdata_i, 2)});
  endproperty
  a_mul: assert property (p_mul) else $error("multiply factor wrong");
  property p_rd_ctl;
    sfr_rd_i && on_ctl |=> sfr_rdata_o[7:4] == {3'b000, $past(lock_indicator_o)} && sfr_rdata_o[2:0] == $past(ctl);
  endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("control read wrong");
  property p_rd_div; sfr_rd_i && on_div |=> sfr_rdata_o[7:5] == 3'b000; endproperty
  a_rd_div: assert property (p_rd_div) else $error("predivider high bits set");
  property p_miss; sfr_rd_i && ce_i && !sfr_hit_o |=> sfr_rdata_o == 8'h00; endproperty
  a_miss: assert property (p_miss) else $error("unmapped read not zero");
  property p_lock_off; !(bias_power_enable_o && synth_run_enable_o) |=> !lock_indicator_o; endproperty
  a_lock_off: assert property (p_lock_off) else $error("lock shown while stopped");
  property p_lock_rise; $rose(lock_indicator_o) |-> run_n >= LOCK_FILTER; endproperty
  a_lock_rise: assert property (p_lock_rise) else $error("lock shown too early");
endmodule
bind scr_synth_ctrl scr_synth_ctrl_sva #(.LOCK_FILTER(LOCK_FILTER)) u_sva (
  .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .sfr_page_i(sfr_page_i), .sfr_addr_i(sfr_addr_i),
  .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_hit_o(sfr_hit_o),
  .sfr_rdata_o(sfr_rdata_o), .loop_locked_i(loop_locked_i),
  .reference_source_select_o(reference_source_select_o), .synth_run_enable_o(synth_run_enable_o),
  .bias_power_enable_o(bias_power_enable_o), .predivide_factor_o(predivide_factor_o),
  .multiply_factor_o(multiply_factor_o), .lock_indicator_o(lock_indicator_o));
`default_nettype wire

/* test/tb.sv */
/* Self-checking bench for the synthesizer control block.
   Assumes the loop model stands on the analog side. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import scr_pkg::*;
  logic       clk_i = 1'b0, nrst_i = 1'b0, ce_i = 1'b1, wr = 1'b0, rd = 1'b0, drop = 1'b0;
  logic [7:0] page = SCR_PAGE, addr = 8'h00, wdata = 8'h00, delay = 8'h14, d, m, rdata;
  logic       hit, src, run, pwr, lock, locked, pend = 1'b0;
  logic [5:0] pdf;
  logic [8:0] mf;
  logic [1:0] osc;
  logic [3:0] lp;
  logic [7:0] expq[$];
  int         bad_count = 0, num_checks = 0, seed = 93;
  always #50 clk_i = ~clk_i;
  // Filter placed apart from the multiplier so both can be reached.
  scr_synth_ctrl #(.FLT_ADDR(8'h8E)) uut (
    .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .sfr_page_i(page), .sfr_addr_i(addr),
    .sfr_wdata_i(wdata), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_hit_o(hit), .sfr_rdata_o(rdata),
    .loop_locked_i(locked), .reference_source_select_o(src), .synth_run_enable_o(run),
    .bias_power_enable_o(pwr), .predivide_factor_o(pdf), .multiply_factor_o(mf),
    .osc_range_select_o(osc), .loop_filter_range_o(lp), .lock_indicator_o(lock));
  scr_loop_model u_loop (.clk_i(clk_i), .nrst_i(nrst_i), .pwr_i(pwr), .run_i(run), .drop_i(drop),
    .delay_i(delay), .locked_o(locked));
  task automatic test_done;
    if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Read data is due one edge after a taken read; the oldest note is compared then.
  always @(posedge clk_i) pend <= nrst_i && ce_i && rd;
  always @(negedge clk_i) if (pend === 1'b1) begin
    if (expq.size() == 0) chk(9'h1FF, 9'h000);
    else chk({1'b0, rdata}, {1'b0, expq.pop_front()});
  end
  // One access per cycle; strobes stay up so back-to-back calls never toggle a signal twice.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
    if (!w) expq.push_back(v);
    wr = w;
    rd = !w;
    addr = a;
    wdata = v;
    @(negedge clk_i);
  endtask
  task automatic idle(input int n);
    wr = 1'b0;
    rd = 1'b0;
    repeat (n) @(negedge clk_i);
  endtask
  // Holds reset three cycles, then reads back every register.
  task automatic rst_chk;
    nrst_i = 1'b0;
    idle(3);
    nrst_i = 1'b1;
    acc(1'b0, 8'h89, 8'h00);
    acc(1'b0, 8'h8D, 8'h01);
    acc(1'b0, 8'h8F, 8'h01);
    acc(1'b0, 8'h8E, 8'h31);
    idle(1);
    chk({3'b000, pdf}, 9'd1);
    chk(mf, 9'd1);
    chk({3'b000, osc, lp}, 9'h031);
    chk({8'h00, hit}, 9'h001);
  endtask
  // Bounded wait for the lock flag; running out ends the run.
  task automatic wait_lock;
    for (int n = 0; n < 100 && lock !== 1'b1; n++) @(negedge clk_i);
    chk({8'h00, lock}, 9'h001);
    if (lock !== 1'b1) test_done();
  endtask
  initial begin
    rst_chk();
    for (int i = 0; i < 10; i++) begin
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'hE0 : 8'($random(seed));
      m = (i == 0) ? 8'h00 : 8'($random(seed));
      acc(1'b1, 8'h8D, d);
      acc(1'b1, 8'h8F, m);
      acc(1'b0, 8'h8D, d & 8'h1F);
      acc(1'b0, 8'h8F, m);
      chk({3'b000, pdf}, (d[4:0] == 5'h00) ? 9'd32 : {4'h0, d[4:0]});
      chk(mf, (m == 8'h00) ? 9'd256 : {1'b0, m});
    end
    for (int i = 0; i < 4; i++) begin
      d = {2'b11, 2'(i), 4'((1 << (i + 1)) - 1)};
      acc(1'b1, 8'h8E, d);
      acc(1'b0, 8'h8E, d & 8'h3F);
      chk({3'b000, osc, lp}, {3'b000, d[5:0]});
    end
    page = 8'h00;
    acc(1'b0, 8'h89, 8'h00);
    chk({8'h00, hit}, 9'h000);
    page = SCR_PAGE;
    acc(1'b1, 8'h8C, 8'hFF);
    acc(1'b0, 8'h8C, 8'h00);
    chk({8'h00, hit}, 9'h000);
    ce_i = 1'b0;
    acc(1'b1, 8'h8F, 8'h55);
    ce_i = 1'b1;
    acc(1'b0, 8'h8F, m);
    acc(1'b1, 8'h89, 8'hF5);
    idle(50);
    acc(1'b1, 8'h89, 8'h07);
    idle(1);
    chk({6'h00, src, run, pwr}, 9'h007);
    chk({8'h00, lock}, 9'h000);
    wait_lock();
    acc(1'b0, 8'h89, 8'h17);
    drop = 1'b1;
    idle(2);
    chk({8'h00, lock}, 9'h000);
    drop = 1'b0;
    delay = 8'h00;
    wait_lock();
    // A new ratio under a running loop must clear the flag until lock is qualified again.
    acc(1'b1, 8'h8F, m ^ 8'h01);
    chk({8'h00, lock}, 9'h000);
    wait_lock();
    acc(1'b1, 8'h89, 8'h05);
    idle(2);
    chk({8'h00, lock}, 9'h000);
    acc(1'b0, 8'h89, 8'h05);
    rst_chk();
    test_done();
  end
endmodule
`default_nettype wire
